// ==== rtl/brw_top.sv ====
`timescale 1ns/100ps
// Function
// - Burst gap wait zero to three cycles.
// - First access wait from four-bit code.
// - Mask bit clear honours external wait.
// - Unmasked wait stretches even zero-wait access.
// - Reserved bits read zero, written zero.
// - Reset: first wait 1010, others zero.
module brw_top
	import brw_pkg::*;
#(
	parameter int BURST_W = 4
)(
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire logic [brw_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [brw_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [brw_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [brw_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       accReq,
	input  wire logic [BURST_W-1:0]         accBurstLen,
	input  wire logic                       extWait,
	output logic                            accStrobe,
	output logic                            accBusy
);
	import brw_pkg::*;

	logic [1:0]              burstGapWait;
	logic [3:0]              firstAccessWait;
	logic                    externalWaitMask;
	logic                    awGot;
	logic                    wGot;
	logic [ADDR_W-1:0]       awAddr;
	logic [DATA_W-1:0]       wData;
	logic [3:0]              wStrb;
	brw_state_t              state;
	brw_state_t              next_state;
	logic [BURST_W-1:0]      remain;
	logic                    timerLoad;
	logic [WAIT_W-1:0]       timerValue;
	logic [WAIT_W-1:0]       waitLeft;
	logic                    expired;
	logic                    stall;
	logic                    accDone;
	logic                    active;
	logic [DATA_W-1:0]       regImage;
	logic [WAIT_W-1:0]       spentWait;
	logic [3:0]              firstCodeTaken;
	logic [1:0]              gapCodeTaken;

	// Live fields assembled into the read image; reserved bits stay zero.
	always_comb begin
		regImage = '0;
		regImage[GAP_MSB:GAP_LSB]     = burstGapWait;
		regImage[FIRST_MSB:FIRST_LSB] = firstAccessWait;
		regImage[MASK_POS]            = externalWaitMask;
	end

	// Write address and data are taken independently, in either order.
	// Ready is raised for one cycle after valid, so the master must hold.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			awGot         <= 1'b0;
			awAddr        <= '0;
		end else begin
			s_axi_awready <= s_axi_awvalid && !s_axi_awready && !awGot
				&& !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awGot  <= 1'b1;
				awAddr <= s_axi_awaddr;
			end else if (awGot && wGot) begin
				awGot <= 1'b0;
			end
		end
	end

	// Write data channel, mirror of the address channel.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_axi_wready <= 1'b0;
			wGot         <= 1'b0;
			wData        <= '0;
			wStrb        <= '0;
		end else begin
			s_axi_wready <= s_axi_wvalid && !s_axi_wready && !wGot
				&& !s_axi_bvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				wGot  <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end else if (awGot && wGot) begin
				wGot <= 1'b0;
			end
		end
	end

	// Register update and write response once both halves are held.
	// Byte lanes gate each field; the first-wait field spans two lanes.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			burstGapWait     <= GAP_RST;
			firstAccessWait  <= FIRST_RST;
			externalWaitMask <= MASK_RST;
			s_axi_bvalid     <= 1'b0;
			s_axi_bresp      <= RESP_OKAY;
		end else if (awGot && wGot) begin
			s_axi_bvalid <= 1'b1;
			if (awAddr == WAIT_CONFIG_OFS) begin
				s_axi_bresp <= RESP_OKAY;
				if (wStrb[2]) begin
					burstGapWait <= wData[GAP_MSB:GAP_LSB];
				end
				if (wStrb[1]) begin
					firstAccessWait[3:1] <= wData[FIRST_MSB:FIRST_LSB+1];
				end
				if (wStrb[0]) begin
					firstAccessWait[0] <= wData[FIRST_LSB];
					externalWaitMask   <= wData[MASK_POS];
				end
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel; unmapped addresses answer zero with a slave error.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready
				&& !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				if (s_axi_araddr == WAIT_CONFIG_OFS) begin
					s_axi_rdata <= regImage & LIVE_BITS;
					s_axi_rresp <= RESP_OKAY;
				end else begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// An access phase ends only when the count is spent and the ROM lets go or the mask bit is set.
	assign active  = (state != ST_IDLE);
	assign stall   = extWait && !externalWaitMask;
	assign accDone = active && expired && !stall;

	// Sequencer: first access, then gaps until the burst is used up.
	always_comb begin
		next_state = state;
		timerLoad  = 1'b0;
		timerValue = first_wait(firstAccessWait);
		case (state)
			ST_IDLE: begin
				if (accReq) begin
					next_state = ST_FIRST;
					timerLoad  = 1'b1;
				end
			end
			ST_FIRST, ST_GAP: begin
				if (accDone) begin
					if (remain == '0) begin
						next_state = ST_IDLE;
					end else begin
						next_state = ST_GAP;
						timerLoad  = 1'b1;
						timerValue = {3'h0, burstGapWait};
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State, remaining accesses and the registered outputs.
	// A burst length of zero is run as a single access.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state     <= ST_IDLE;
			remain    <= '0;
			accStrobe <= 1'b0;
			accBusy   <= 1'b0;
		end else begin
			state     <= next_state;
			accStrobe <= accDone;
			accBusy   <= (next_state != ST_IDLE);
			if (state == ST_IDLE && accReq) begin
				remain <= (accBurstLen == '0) ? '0 : accBurstLen - 1'b1;
			end else if (accDone && remain != '0) begin
				remain <= remain - 1'b1;
			end
		end
	end

	// Wait cycle counter shared by first and gap phases.
	brw_wait_timer brw_wait_timer_i (
		.clk       (clk),
		.nrst      (nrst),
		.load      (timerLoad),
		.loadValue (timerValue),
		.waitLeft  (waitLeft),
		.expired   (expired)
	);

	// Helper for the checks: wait cycles spent in the running phase.
	// Cycles in which the ROM holds a spent count are not counted.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			spentWait <= '0;
		end else if (timerLoad || !active) begin
			spentWait <= '0;
		end else if (!expired) begin
			spentWait <= spentWait + 5'h01;
		end
	end

	// Codes in force for the running phases, kept for the checks below.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			firstCodeTaken <= FIRST_RST;
			gapCodeTaken   <= GAP_RST;
		end else if (state == ST_IDLE && accReq) begin
			firstCodeTaken <= firstAccessWait;
		end else if (accDone) begin
			gapCodeTaken <= burstGapWait;
		end
	end

	// Checks next to the logic above.
	a_gap_load: assert property (@(posedge clk) disable iff (!nrst)
		(timerLoad && state != ST_IDLE) |=>
			(waitLeft == {3'h0, $past(burstGapWait)}))
		else $error("gap wait count not loaded from field");

	a_first_load: assert property (@(posedge clk) disable iff (!nrst)
		(state == ST_IDLE && accReq) |=>
			(state == ST_FIRST
			&& waitLeft == first_wait($past(firstAccessWait))))
		else $error("first wait count wrong");

	a_mask_ignore: assert property (@(posedge clk) disable iff (!nrst)
		(active && expired && externalWaitMask) |=> accStrobe)
		else $error("masked wait still held access");

	a_zero_stretch: assert property (@(posedge clk) disable iff (!nrst)
		(active && expired && extWait && !externalWaitMask) |=>
			(!accStrobe && state == $past(state)))
		else $error("external wait did not stretch access");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
		s_axi_rvalid |-> ((s_axi_rdata & ~LIVE_BITS) == '0))
		else $error("reserved bits read nonzero");

	a_reset_vals: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> (firstAccessWait == FIRST_RST
			&& burstGapWait == GAP_RST && externalWaitMask == MASK_RST))
		else $error("wait fields wrong after reset");

	a_wait_hold: assert property (@(posedge clk) disable iff (!nrst)
		(active && !expired) |=> (!accStrobe && active))
		else $error("access ended before wait count spent");

	// Answers stand until the master takes them.
	a_bvalid_hold: assert property (@(posedge clk) disable iff (!nrst)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("write answer dropped before taken");

	a_rvalid_hold: assert property (@(posedge clk) disable iff (!nrst)
		(s_axi_rvalid && !s_axi_rready) |=>
			(s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read answer changed before taken");

	// A write to another address must leave every field alone.
	a_unmapped_keep: assert property (@(posedge clk) disable iff (!nrst)
		(awGot && wGot && awAddr != WAIT_CONFIG_OFS) |=>
			$stable(regImage))
		else $error("unmapped write changed a field");

	// A full-width write lands in the live fields only.
	a_write_lands: assert property (@(posedge clk) disable iff (!nrst)
		(awGot && wGot && awAddr == WAIT_CONFIG_OFS && wStrb == 4'hf) |=>
			(regImage == ($past(wData) & LIVE_BITS)))
		else $error("full write did not land in fields");

	// The timer rests at zero between bursts, so a new one starts clean.
	a_idle_spent: assert property (@(posedge clk) disable iff (!nrst)
		!active |-> expired)
		else $error("wait count left running while idle");

	a_first_span: assert property (@(posedge clk) disable iff (!nrst)
		(state == ST_FIRST && accDone) |->
			(spentWait == first_wait(firstCodeTaken)))
		else $error("first access ended after wrong wait");

	a_gap_span: assert property (@(posedge clk) disable iff (!nrst)
		(state == ST_GAP && accDone) |->
			(spentWait == {3'h0, gapCodeTaken}))
		else $error("burst gap ended after wrong wait");
endmodule

// ==== rtl/brw_pkg.sv ====
package brw_pkg;
	// Bus widths of the register port.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Byte address of the wait configuration register.
	localparam logic [ADDR_W-1:0] WAIT_CONFIG_OFS = 4'h0;

	// Field positions inside the wait configuration register.
	localparam int GAP_LSB  = 16;
	localparam int GAP_MSB  = 17;
	localparam int FIRST_LSB = 7;
	localparam int FIRST_MSB = 10;
	localparam int MASK_POS  = 6;

	// Bits that hold state; everything else reads as zero.
	localparam logic [DATA_W-1:0] LIVE_BITS = 32'h0003_07c0;

	// Reset values of the fields.
	localparam logic [1:0] GAP_RST   = 2'h0;
	localparam logic [3:0] FIRST_RST = 4'ha;
	localparam logic       MASK_RST  = 1'b0;

	// Width of a wait count; the longest first wait is 24 cycles.
	localparam int WAIT_W = 5;

	// Access wait codes that do not map one to one.
	localparam logic [3:0] FIRST_CODE_LINEAR_MAX = 4'h6;
	localparam logic [WAIT_W-1:0] WAIT_CODE7  = 5'h08;
	localparam logic [WAIT_W-1:0] WAIT_CODE8  = 5'h0a;
	localparam logic [WAIT_W-1:0] WAIT_CODE9  = 5'h0c;
	localparam logic [WAIT_W-1:0] WAIT_CODE10 = 5'h0e;
	localparam logic [WAIT_W-1:0] WAIT_CODE11 = 5'h12;
	localparam logic [WAIT_W-1:0] WAIT_CODE12 = 5'h18;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Access sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FIRST,
		ST_GAP
	} brw_state_t;

	// Wait cycles for a first access wait code.
	function automatic logic [WAIT_W-1:0] first_wait(input logic [3:0] code);
		logic [WAIT_W-1:0] cycles;
		cycles = WAIT_CODE12;
		if (code <= FIRST_CODE_LINEAR_MAX) begin
			cycles = {1'b0, code};
		end else if (code == 4'h7) begin
			cycles = WAIT_CODE7;
		end else if (code == 4'h8) begin
			cycles = WAIT_CODE8;
		end else if (code == 4'h9) begin
			cycles = WAIT_CODE9;
		end else if (code == 4'ha) begin
			cycles = WAIT_CODE10;
		end else if (code == 4'hb) begin
			cycles = WAIT_CODE11;
		end
		return cycles;
	endfunction
endpackage

// ==== rtl/brw_wait_timer.sv ====
`timescale 1ns/100ps
module brw_wait_timer
	import brw_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire logic                       load,
	input  wire logic [brw_pkg::WAIT_W-1:0] loadValue,
	output logic      [brw_pkg::WAIT_W-1:0] waitLeft,
	output logic                            expired
);
	// Counts the programmed wait cycles down in bus clock periods.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			waitLeft <= '0;
		end else if (load) begin
			waitLeft <= loadValue;
		end else if (waitLeft != '0) begin
			waitLeft <= waitLeft - 5'h01;
		end
	end

	// The external wait is applied by the caller, not here.
	assign expired = (waitLeft == '0);
endmodule

// ==== test/brw_rom_model.sv ====
`timescale 1ns/100ps
// Behavioural burst ROM on area 0; it stretches an access only on command.
module brw_rom_model (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic accBusy,
	input  wire logic holdWait,
	output logic      extWait
);
	logic idleNoise;

	// A deselected ROM leaves the wait line floating, so it must not settle.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			idleNoise <= 1'b0;
		end else begin
			idleNoise <= ~idleNoise;
		end
	end

	// While selected, wait is held as long as the bench asks.
	assign extWait = accBusy ? holdWait : idleNoise;
endmodule

// ==== test/brw_top_tb_top.sv ====
`timescale 1ns/100ps
module brw_top_tb_top;
	import brw_pkg::*;
	logic              clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic              accReq, extWait, holdWait, accStrobe, accBusy;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata, q;
	logic [1:0]        bresp, rresp, r;
	logic [3:0]        burstLen;
	logic [3:0]        strb;
	int                nErrors, checksDone;
	int                firstTbl[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12,
		14, 18, 24};

	brw_top brw_top_i (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .accReq(accReq),
		.accBurstLen(burstLen), .extWait(extWait), .accStrobe(accStrobe),
		.accBusy(accBusy));
	brw_rom_model brw_rom_model_i (.clk(clk), .nrst(nrst), .accBusy(accBusy),
		.holdWait(holdWait), .extWait(extWait));

	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] exp, got);
		checksDone++;
		if (got !== exp) begin
			nErrors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One bus transfer; every channel is held until its handshake edge.
	task automatic bus(input bit wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] rq, output logic [1:0] rs);
		logic tA, tW, tR;
		@(posedge clk);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= wr;
		wvalid <= wr;
		bready <= wr;
		arvalid <= !wr;
		rready <= !wr;
		tR = 1'b0;
		while (!tR) begin
			#1;
			tA = (awvalid && awready) || (arvalid && arready);
			tW = wvalid && wready;
			tR = wr ? bvalid : rvalid;
			rq = rdata;
			rs = wr ? bresp : rresp;
			@(posedge clk);
			if (tA) begin
				awvalid <= 1'b0;
				arvalid <= 1'b0;
			end
			if (tW) wvalid <= 1'b0;
			if (tR) begin
				bready <= 1'b0;
				rready <= 1'b0;
			end
		end
	endtask

	// Starts a burst and times each strobe against the expected wait.
	task automatic access(input logic [3:0] len, input int first, gap);
		int n, want;
		@(posedge clk);
		accReq <= 1'b1;
		burstLen <= len;
		@(posedge clk);
		accReq <= 1'b0;
		for (int i = 0; i < len; i++) begin
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (!accStrobe && n < 40);
			want = (i == 0) ? first + 1 : gap + 1;
			check("strobe delay", want, n);
		end
		check("busy after burst", 32'h0, accBusy);
		for (int k = 0; k < 5 && accBusy; k++) @(posedge clk);
	endtask

	// Reset contents, the unmapped address, and a first access at reset.
	task automatic t_reset;
		bus(1'b0, WAIT_CONFIG_OFS, '0, q, r);
		check("config after reset", 32'h0000_0500, q);
		bus(1'b1, 4'h8, 32'h0000_0040, q, r);
		check("unmapped write resp", 32'h2, r);
		bus(1'b0, 4'h4, '0, q, r);
		check("unmapped read resp", 32'h2, r);
		bus(1'b0, WAIT_CONFIG_OFS, '0, q, r);
		check("config kept", 32'h0000_0500, q);
		access(4'h1, 14, 0);
		strb <= 4'h4;
		bus(1'b1, WAIT_CONFIG_OFS, 32'h0003_0040, q, r);
		strb <= 4'hf;
		bus(1'b0, WAIT_CONFIG_OFS, '0, q, r);
		check("lane write readback", 32'h0003_0500, q);
		access(4'h2, 14, 3);
	endtask

	// Every legal access code, each with burst gap code c mod 4; codes stop at 1100.
	task automatic t_codes;
		logic [31:0] cfg;
		for (int c = 0; c < 13; c++) begin
			cfg = {14'h0, c[1:0], 5'h0, c[3:0], 1'b1, 6'h0};
			bus(1'b1, WAIT_CONFIG_OFS, cfg, q, r);
			bus(1'b0, WAIT_CONFIG_OFS, '0, q, r);
			check("config readback", cfg, q);
			access(4'h2, firstTbl[c], c % 4);
		end
	endtask

	// A held external wait stretches a zero-wait access unless masked.
	task automatic t_mask;
		int seen;
		bus(1'b1, WAIT_CONFIG_OFS, 32'h0, q, r);
		@(posedge clk);
		holdWait <= 1'b1;
		accReq <= 1'b1;
		burstLen <= 4'h1;
		@(posedge clk);
		accReq <= 1'b0;
		seen = 0;
		repeat (20) begin
			@(posedge clk);
			#1;
			if (accStrobe) seen++;
		end
		check("strobe while held", 0, seen);
		check("busy while held", 32'h1, accBusy);
		@(posedge clk);
		holdWait <= 1'b0;
		for (int k = 0; k < 4 && seen == 0; k++) begin
			@(posedge clk);
			#1;
			if (accStrobe) seen++;
		end
		check("strobe after release", 1, seen);
		bus(1'b1, WAIT_CONFIG_OFS, 32'h0000_0040, q, r);
		holdWait <= 1'b1;
		access(4'h1, 0, 0);
		@(posedge clk);
		holdWait <= 1'b0;
	endtask

	task automatic results;
		$display("errors %0d, checks %0d", nErrors, checksDone);
		if (nErrors == 0 && checksDone > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence: reset for six cycles, then the scenarios.
	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
		{accReq, holdWait, awaddr, araddr, wdata, burstLen} = '0;
		strb = 4'hf;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_codes();
		t_mask();
		results();
	end

	// Watchdog, far beyond the roughly four hundred cycles needed.
	initial begin
		repeat (20000) @(posedge clk);
		nErrors++;
		results();
	end
endmodule
